/* rtl/rtcat_top.sv */
// alarm value, timestamp capture and calibration prescaler of the clock/calendar
`timescale 1ns/10ps
`default_nettype none
`include "rtcat_defines.svh"

module rtcat_top
   import rtcat_pkg::*;
(
   // clock and resets
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic por_resetn,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [5:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output rtcat_pkg::rtcat_resp_t bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [5:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output rtcat_pkg::rtcat_resp_t rresp,
   // running time and date from the counters
   input wire rtcat_pkg::rtcat_word_t now_seconds,
   input wire rtcat_pkg::rtcat_word_t now_hours_minutes,
   input wire rtcat_pkg::rtcat_word_t now_day_weekday,
   input wire rtcat_pkg::rtcat_word_t now_year_month,
   // timestamp request pin, low pulse
   input wire logic capture_pin_n,
   // prescaler and event outputs
   output logic half_second_tick,
   output logic half_second_phase,
   output logic alarm_pulse,
   output logic irq
);
   import rtcat_pkg::*;

   // ************************************************************
   // helpers
   // ************************************************************
   // bcd digit compare under a field mask, no conversion
   function automatic logic fields_match(input rtcat_word_t a, input rtcat_word_t b, input rtcat_word_t m);
      fields_match = ((a ^ b) & m) == 16'h0000;
   endfunction

   function automatic rtcat_word_t strobe_merge(input rtcat_word_t old, input logic [15:0] nw,
                                                input logic [1:0] be, input rtcat_word_t m);
      rtcat_word_t lane;
      lane = {{8{be[1]}}, {8{be[0]}}};
      strobe_merge = (old & ~(lane & m)) | (nw & lane & m);
   endfunction

   // ************************************************************
   // state
   // ************************************************************
   rtcat_word_t alm_q [4];
   rtcat_word_t cap_q [4];
   logic [15:0] coarse_q;
   logic [4:0] fine_q;
   logic cap_en_q;
   logic alm_en_q;
   logic [3:0] sel_q;
   logic [15:0] status_q;
   logic [15:0] status_d;
   logic [15:0] irq_mask_q;
   logic [15:0] cnt_q;
   logic [4:0] trim_q;
   logic [4:0] half_cnt_q;
   logic half_tick_q;
   logic phase_q;
   logic alm_pulse_q;
   logic irq_q;
   logic pin_s1_q;
   logic pin_s2_q;
   logic pin_s3_q;

   // ************************************************************
   // axi4-lite write channel
   // ************************************************************
   logic aw_have_q;
   logic w_have_q;
   logic [5:0] aw_addr_q;
   logic [15:0] w_data_q;
   logic [1:0] w_be_q;
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   rtcat_resp_t bresp_q;
   wire aw_take = awvalid & awready_q;
   wire w_take = wvalid & wready_q;
   wire do_write = aw_have_q & w_have_q & ~bvalid_q;
   wire aw_have_d = (aw_have_q | aw_take) & ~do_write;
   wire w_have_d = (w_have_q | w_take) & ~do_write;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 6'h00;
         w_data_q <= 16'h0000;
         w_be_q <= 2'h0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         awready_q <= ~aw_have_d;
         wready_q <= ~w_have_d;
         if (aw_take) begin
            aw_addr_q <= awaddr;
         end
         if (w_take) begin
            w_data_q <= wdata[15:0];
            w_be_q <= wstrb[1:0];
         end
      end
   end

   wire wa_alm = do_write & (aw_addr_q[5:4] == 2'h0);
   wire wa_cap = do_write & (aw_addr_q[5:4] == 2'h1);
   wire [1:0] wa_idx = aw_addr_q[3:2];
   wire wa_coarse = do_write & (aw_addr_q == `RTCAT_OFF_COARSE);
   wire wa_fine = do_write & (aw_addr_q == `RTCAT_OFF_FINE);
   wire wa_ctrl = do_write & (aw_addr_q == `RTCAT_OFF_CTRL);
   wire wa_status = do_write & (aw_addr_q == `RTCAT_OFF_STATUS);
   wire wa_mask = do_write & (aw_addr_q == `RTCAT_OFF_IRQ_MASK);
   wire wa_hit = wa_alm | wa_cap | wa_coarse | wa_fine | wa_ctrl | wa_status | wa_mask;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= RTCAT_RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q <= wa_hit ? RTCAT_RESP_OKAY : RTCAT_RESP_SLVERR;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ************************************************************
   // field masks per word
   // ************************************************************
   rtcat_word_t layout [4];
   assign layout[0] = `RTCAT_MASK_SEC;
   assign layout[1] = `RTCAT_MASK_HM;
   assign layout[2] = `RTCAT_MASK_DW;
   assign layout[3] = `RTCAT_MASK_YM;
   wire [15:0] cap_wmask = cap_en_q ? layout[wa_idx] : 16'hffff;

   // ************************************************************
   // alarm value words
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 4; i++) begin
            alm_q[i] <= `RTCAT_RST_WORD;
         end
      end else if (wa_alm) begin
         alm_q[wa_idx] <= strobe_merge(alm_q[wa_idx], w_data_q, w_be_q, layout[wa_idx]);
      end
   end

   // ************************************************************
   // timestamp words, cleared only at power-on
   // ************************************************************
   logic pin_fall;
   logic manual_req;
   logic cap_fire;
   assign pin_fall = pin_s3_q & ~pin_s2_q;
   assign manual_req = wa_status & w_be_q[0] & w_data_q[`RTCAT_ST_CAP];
   assign cap_fire = cap_en_q & ~status_q[`RTCAT_ST_CAP] & (pin_fall | manual_req);

   always_ff @(posedge aclk) begin
      if (!por_resetn) begin
         for (int i = 0; i < 4; i++) begin
            cap_q[i] <= `RTCAT_RST_WORD;
         end
      end else if (cap_fire) begin
         cap_q[0] <= now_seconds & `RTCAT_MASK_SEC;
         cap_q[1] <= now_hours_minutes & `RTCAT_MASK_HM;
         cap_q[2] <= now_day_weekday & `RTCAT_MASK_DW;
         cap_q[3] <= now_year_month & `RTCAT_MASK_YM;
      end else if (wa_cap) begin
         cap_q[wa_idx] <= strobe_merge(cap_q[wa_idx], w_data_q, w_be_q, cap_wmask);
      end
   end

   // ************************************************************
   // control and calibration words
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         coarse_q <= `RTCAT_RST_COARSE;
         fine_q <= 5'h00;
         cap_en_q <= 1'b0;
         alm_en_q <= 1'b0;
         sel_q <= 4'h0;
         irq_mask_q <= 16'h0000;
      end else begin
         if (wa_coarse) begin
            coarse_q <= strobe_merge(coarse_q, w_data_q, w_be_q, 16'hffff);
         end
         if (wa_fine & w_be_q[1]) begin
            fine_q <= w_data_q[`RTCAT_FINE_LSB +: 5];
         end
         if (wa_ctrl & w_be_q[0]) begin
            cap_en_q <= w_data_q[`RTCAT_CTRL_CAP_EN];
         end
         if (wa_ctrl & w_be_q[1]) begin
            sel_q <= w_data_q[`RTCAT_CTRL_SEL_LSB +: 4];
            alm_en_q <= w_data_q[`RTCAT_CTRL_ALM_EN];
         end
         if (wa_mask) begin
            irq_mask_q <= strobe_merge(irq_mask_q, w_data_q, w_be_q, `RTCAT_ST_MASK);
         end
      end
   end

   // ************************************************************
   // prescaler
   // ************************************************************
   wire cnt_zero = cnt_q == 16'h0000;
   wire trim_due = half_cnt_q == `RTCAT_HALF_PER_TRIM;
   wire underflow = cnt_zero & (trim_q == 5'h00);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= `RTCAT_RST_COARSE;
         trim_q <= 5'h00;
         half_cnt_q <= 5'h00;
         half_tick_q <= 1'b0;
         phase_q <= 1'b0;
      end else begin
         half_tick_q <= underflow;
         if (!cnt_zero) begin
            cnt_q <= cnt_q - 16'h0001;
         end else if (trim_q != 5'h00) begin
            trim_q <= trim_q - 5'h01;
         end else begin
            cnt_q <= coarse_q;
            half_cnt_q <= half_cnt_q + 5'h01;
            phase_q <= ~phase_q;
            // one stretch per 32 half seconds
            trim_q <= trim_due ? fine_q : 5'h00;
         end
      end
   end

   // ************************************************************
   // alarm compare
   // ************************************************************
   wire m_s1 = fields_match(alm_q[0], now_seconds, `RTCAT_MASK_SEC_UNITS);
   wire m_sec = fields_match(alm_q[0], now_seconds, `RTCAT_MASK_SEC);
   wire m_m1 = fields_match(alm_q[1], now_hours_minutes, `RTCAT_MASK_MIN_UNITS);
   wire m_min = fields_match(alm_q[1], now_hours_minutes, `RTCAT_MASK_MIN);
   wire m_hr = fields_match(alm_q[1], now_hours_minutes, `RTCAT_MASK_HOUR);
   wire m_wd = fields_match(alm_q[2], now_day_weekday, `RTCAT_MASK_WEEKDAY_VALUE);
   wire m_dt = fields_match(alm_q[2], now_day_weekday, `RTCAT_MASK_DATE);
   wire m_mo = fields_match(alm_q[3], now_year_month, `RTCAT_MASK_MONTH);
   logic sel_match;
   always_comb begin
      unique case (rtcat_interval_t'(sel_q))
         RTCAT_EVERY_HALF: sel_match = 1'b1;
         RTCAT_EVERY_SEC: sel_match = ~phase_q;
         RTCAT_EVERY_TEN_SEC: sel_match = ~phase_q & m_s1;
         RTCAT_EVERY_MIN: sel_match = ~phase_q & m_sec;
         RTCAT_EVERY_TEN_MIN: sel_match = ~phase_q & m_sec & m_m1;
         RTCAT_EVERY_HOUR: sel_match = ~phase_q & m_sec & m_min;
         RTCAT_EVERY_DAY: sel_match = ~phase_q & m_sec & m_min & m_hr;
         RTCAT_EVERY_WEEK: sel_match = ~phase_q & m_sec & m_min & m_hr & m_wd;
         RTCAT_EVERY_MONTH: sel_match = ~phase_q & m_sec & m_min & m_hr & m_dt;
         RTCAT_EVERY_YEAR: sel_match = ~phase_q & m_sec & m_min & m_hr & m_dt & m_mo;
         default: sel_match = 1'b0;
      endcase
   end
   wire alm_hit = alm_en_q & half_tick_q & sel_match;

   // ************************************************************
   // pin synchroniser and status
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_q <= 1'b1;
         pin_s2_q <= 1'b1;
         pin_s3_q <= 1'b1;
      end else begin
         pin_s1_q <= capture_pin_n;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   logic ar_take;
   wire ra_status = ar_take & (araddr == `RTCAT_OFF_STATUS);
   wire [15:0] st_set = ({15'h0000, half_tick_q} << `RTCAT_ST_HALF)
                      | ({15'h0000, cap_fire} << `RTCAT_ST_CAP)
                      | ({15'h0000, alm_hit} << `RTCAT_ST_ALM);
   // read clears, a set in the same cycle wins
   assign status_d = ((ra_status ? 16'h0000 : status_q) | st_set) & `RTCAT_ST_MASK;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= 16'h0000;
         alm_pulse_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         status_q <= status_d;
         alm_pulse_q <= alm_hit;
         irq_q <= |(status_d & irq_mask_q);
      end
   end

   // ************************************************************
   // axi4-lite read channel
   // ************************************************************
   logic arready_q;
   logic rvalid_q;
   logic [15:0] rdata_q;
   rtcat_resp_t rresp_q;
   logic [15:0] rd_word;
   logic rd_hit;
   assign ar_take = arvalid & arready_q;
   wire rvalid_d = ar_take | (rvalid_q & ~rready);
   wire [1:0] ra_idx = araddr[3:2];
   wire [15:0] cap_rmask = cap_en_q ? layout[ra_idx] : 16'hffff;

   always_comb begin
      rd_hit = 1'b1;
      unique case (araddr)
         `RTCAT_OFF_ALM_SEC, `RTCAT_OFF_ALM_HM, `RTCAT_OFF_ALM_DW, `RTCAT_OFF_ALM_YM:
            rd_word = alm_q[ra_idx];
         `RTCAT_OFF_CAP_SEC, `RTCAT_OFF_CAP_HM, `RTCAT_OFF_CAP_DW, `RTCAT_OFF_CAP_YM:
            rd_word = cap_q[ra_idx] & cap_rmask;
         `RTCAT_OFF_COARSE: rd_word = coarse_q;
         `RTCAT_OFF_FINE: rd_word = {fine_q, 11'h000};
         `RTCAT_OFF_CTRL: rd_word = {alm_en_q, 3'h0, sel_q, 7'h00, cap_en_q};
         `RTCAT_OFF_STATUS: rd_word = status_q;
         `RTCAT_OFF_IRQ_MASK: rd_word = irq_mask_q;
         default: begin
            rd_word = 16'h0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 16'h0000;
         rresp_q <= RTCAT_RESP_OKAY;
      end else begin
         arready_q <= ~rvalid_d;
         rvalid_q <= rvalid_d;
         if (ar_take) begin
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? RTCAT_RESP_OKAY : RTCAT_RESP_SLVERR;
         end
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = {16'h0000, rdata_q};
   assign rresp = rresp_q;
   assign half_second_tick = half_tick_q;
   assign half_second_phase = phase_q;
   assign alarm_pulse = alm_pulse_q;
   assign irq = irq_q;

endmodule // rtcat_top
`default_nettype wire

/* rtl/rtcat_defines.svh */
// register map, field layout, reset values and counts of the alarm/timestamp/calibration block
`ifndef RTCAT_DEFINES_SVH
`define RTCAT_DEFINES_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define RTCAT_OFF_ALM_SEC 6'h00
`define RTCAT_OFF_ALM_HM 6'h04
`define RTCAT_OFF_ALM_DW 6'h08
`define RTCAT_OFF_ALM_YM 6'h0c
`define RTCAT_OFF_CAP_SEC 6'h10
`define RTCAT_OFF_CAP_HM 6'h14
`define RTCAT_OFF_CAP_DW 6'h18
`define RTCAT_OFF_CAP_YM 6'h1c
`define RTCAT_OFF_COARSE 6'h20
`define RTCAT_OFF_FINE 6'h24
`define RTCAT_OFF_CTRL 6'h28
`define RTCAT_OFF_STATUS 6'h2c
`define RTCAT_OFF_IRQ_MASK 6'h30

// ************************************************************
// digit field masks of the time and date words
// ************************************************************
`define RTCAT_MASK_SEC 16'h7f00
`define RTCAT_MASK_HM 16'h3f7f
`define RTCAT_MASK_DW 16'h3f07
`define RTCAT_MASK_YM 16'hff1f
`define RTCAT_MASK_SEC_UNITS 16'h0f00
`define RTCAT_MASK_MIN_UNITS 16'h000f
`define RTCAT_MASK_MIN 16'h007f
`define RTCAT_MASK_HOUR 16'h3f00
`define RTCAT_MASK_WEEKDAY_VALUE 16'h0007
`define RTCAT_MASK_DATE 16'h3f00
`define RTCAT_MASK_MONTH 16'h001f

// ************************************************************
// control, fine trim and status fields
// ************************************************************
`define RTCAT_CTRL_CAP_EN 0
`define RTCAT_CTRL_SEL_LSB 8
`define RTCAT_CTRL_ALM_EN 15
`define RTCAT_FINE_LSB 11
`define RTCAT_ST_HALF 0
`define RTCAT_ST_CAP 3
`define RTCAT_ST_ALM 5
`define RTCAT_ST_MASK 16'h0029

// ************************************************************
// reset values and counts
// ************************************************************
`define RTCAT_RST_WORD 16'h0000
`define RTCAT_RST_COARSE 16'h7fff
`define RTCAT_HALF_PER_TRIM 5'h1f

`endif

/* rtl/rtcat_pkg.sv */
// types shared by the alarm/timestamp/calibration block
package rtcat_pkg;

   // alarm interval codes of the match select field
   typedef enum logic [3:0] {
      RTCAT_EVERY_HALF = 4'h0,
      RTCAT_EVERY_SEC = 4'h1,
      RTCAT_EVERY_TEN_SEC = 4'h2,
      RTCAT_EVERY_MIN = 4'h3,
      RTCAT_EVERY_TEN_MIN = 4'h4,
      RTCAT_EVERY_HOUR = 4'h5,
      RTCAT_EVERY_DAY = 4'h6,
      RTCAT_EVERY_WEEK = 4'h7,
      RTCAT_EVERY_MONTH = 4'h8,
      RTCAT_EVERY_YEAR = 4'h9
   } rtcat_interval_t;

   typedef logic [15:0] rtcat_word_t;

   typedef enum logic [1:0] {
      RTCAT_RESP_OKAY = 2'h0,
      RTCAT_RESP_SLVERR = 2'h2
   } rtcat_resp_t;

endpackage

/* sim/rtcat_sva.sv */
// assertion checker of the alarm/timestamp/calibration ports
`timescale 1ns/10ps
`default_nettype none
module rtcat_sva
   import rtcat_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire rtcat_pkg::rtcat_resp_t bresp,
   // read bus
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   // events
   input wire logic half_second_tick,
   input wire logic half_second_phase,
   input wire logic alarm_pulse,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ****
   // handshakes
   // ****
   sequence s_rd_take;
      arvalid && arready;
   endsequence
   sequence s_rd_answer;
      rvalid && !arready;
   endsequence
   property p_rd_answer;
      s_rd_take |=> s_rd_answer;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   property p_rd_hold;
      rvalid && !rready |=> rvalid && $stable(rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
   property p_rd_upper;
      rvalid |-> rdata[31:16] == 16'h0;
   endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
   property p_wr_hold;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write response dropped");
   property p_aw_refuse;
      awvalid && awready |=> !awready;
   endproperty
   a_aw_refuse: assert property (p_aw_refuse) else $error("address taken twice");
   property p_w_refuse;
      wvalid && wready |=> !wready;
   endproperty
   a_w_refuse: assert property (p_w_refuse) else $error("data taken twice");
   // ****
   // reset, prescaler and alarm timing
   // ****
   property p_quiet;
      disable iff (1'b0) !aresetn |=> !bvalid && !rvalid && !irq && !alarm_pulse && !half_second_tick;
   endproperty
   a_quiet: assert property (p_quiet) else $error("outputs live in reset");
   property p_phase;
      $changed(half_second_phase) |-> half_second_tick;
   endproperty
   a_phase: assert property (p_phase) else $error("phase moved off tick");
   property p_alarm_tick;
      alarm_pulse |-> $past(half_second_tick);
   endproperty
   a_alarm_tick: assert property (p_alarm_tick) else $error("alarm off the half second");
endmodule // rtcat_sva
bind rtcat_top rtcat_sva u_sva (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
   .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
   .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
   .half_second_tick(half_second_tick), .half_second_phase(half_second_phase),
   .alarm_pulse(alarm_pulse), .irq(irq)
);
`default_nettype wire

/* sim/tb_rtc_alarm_timestamp_calibration.sv */
// self-checking bench of the alarm/timestamp/calibration block
`timescale 1ns/10ps
`default_nettype none
`include "rtcat_defines.svh"
module tb_rtc_alarm_timestamp_calibration;
   import rtcat_pkg::*;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic por_resetn = 1'h0;
   logic awvalid = 1'h0;
   logic wvalid = 1'h0;
   logic bready = 1'h0;
   logic arvalid = 1'h0;
   logic rready = 1'h0;
   logic capture_pin_n = 1'h1;
   logic [5:0] awaddr = 6'h0;
   logic [5:0] araddr = 6'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   rtcat_word_t now_w [0:3] = '{16'h0, 16'h0, 16'h0, 16'h0};
   logic awready, wready, bvalid, arready, rvalid, irq, half_second_tick, half_second_phase, alarm_pulse;
   logic [31:0] rdata;
   rtcat_resp_t bresp, rresp;
   int fail_count = 0;
   int checks_done = 0;
   int tk, pu;
   logic [31:0] seed = 32'heb38;
   logic [31:0] d;
   logic [15:0] mdl [0:12];
   logic [15:0] msk [0:12] = '{`RTCAT_MASK_SEC, `RTCAT_MASK_HM, `RTCAT_MASK_DW, `RTCAT_MASK_YM,
      `RTCAT_MASK_SEC, `RTCAT_MASK_HM, `RTCAT_MASK_DW, `RTCAT_MASK_YM, 16'hffff, 16'hf800, 16'h8f01,
      `RTCAT_ST_MASK, `RTCAT_ST_MASK};

   always #25 aclk = ~aclk;

   rtcat_top dut (
      .aclk(aclk), .aresetn(aresetn), .por_resetn(por_resetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .now_seconds(now_w[0]), .now_hours_minutes(now_w[1]), .now_day_weekday(now_w[2]),
      .now_year_month(now_w[3]), .capture_pin_n(capture_pin_n),
      .half_second_tick(half_second_tick), .half_second_phase(half_second_phase),
      .alarm_pulse(alarm_pulse), .irq(irq)
   );

   // ****
   // helpers
   // ****
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // capture words are full storage while capture is off
   function automatic logic [15:0] em(input int i);
      return (i > 3 && i < 8 && !mdl[10][0]) ? 16'hffff : msk[i];
   endfunction
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic tmo(input int n);
      if (n >= 60) begin
         fail_count++;
         complete_run();
      end
   endtask
   task automatic rst(input logic p);
      @(posedge aclk);
      aresetn <= 1'h0;
      por_resetn <= !p;
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      por_resetn <= 1'h1;
      repeat (2) @(posedge aclk);
      for (int i = 0; i < 13; i++) if (p || i < 4 || i > 7) mdl[i] = (i == 8) ? 16'h7fff : 16'h0;
   endtask
   // ****
   // bus cycles
   // ****
   task automatic wr(input logic [5:0] a, input logic [15:0] v);
      int n;
      n = 0;
      @(posedge aclk);
      awvalid <= 1'h1;
      awaddr <= a;
      wvalid <= 1'h1;
      wdata <= {16'h0, v};
      wstrb <= 4'h3;
      bready <= 1'(rnd());
      while (n < 60) begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid && bready) break;
         if (bvalid) bready <= 1'h1;
      end
      tmo(n);
      chk("bresp", bresp, (a < 6'h34) ? RTCAT_RESP_OKAY : RTCAT_RESP_SLVERR);
      bready <= 1'h0;
      if (a < 6'h2c || a == 6'h30) mdl[a[5:2]] = v & em(a[5:2]);
   endtask
   task automatic rd(input logic [5:0] a, output logic [31:0] v);
      int n;
      n = 0;
      @(posedge aclk);
      arvalid <= 1'h1;
      araddr <= a;
      rready <= 1'(rnd());
      while (n < 60) begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid && rready) break;
         if (rvalid) rready <= 1'h1;
      end
      tmo(n);
      v = rdata;
      chk("rresp", rresp, (a < 6'h34) ? RTCAT_RESP_OKAY : RTCAT_RESP_SLVERR);
      rready <= 1'h0;
   endtask
   task automatic rdc(input logic [5:0] a);
      logic [31:0] v;
      rd(a, v);
      chk($sformatf("reg %h", a), v, {16'h0, mdl[a[5:2]] & em(a[5:2])});
   endtask
   // ****
   // scenario steps
   // ****
   task automatic ticks(input int c, input int t);
      int gap, sum, k, n;
      logic ph;
      wr(6'h20, 16'(c));
      wr(6'h24, 16'(t << 11));
      gap = 0;
      sum = 0;
      k = 0;
      n = 0;
      ph = 1'h0;
      while (k < 68 && n < 40000) begin
         @(posedge aclk);
         n++;
         gap++;
         if (half_second_tick === 1'h1) begin
            if (k > 3) sum += gap;
            if (k > 0) chk("phase", half_second_phase, !ph);
            ph = half_second_phase;
            gap = 0;
            k++;
         end
      end
      if (n >= 40000) tmo(60);
      chk("period sum", sum, 64 * (c + 1) + 2 * t);
   endtask
   task automatic cap(input logic pin, input logic blk);
      for (int i = 0; i < 4; i++) now_w[i] <= 16'(rnd());
      @(posedge aclk);
      if (pin) begin
         capture_pin_n <= 1'h0;
         repeat (4) @(posedge aclk);
         capture_pin_n <= 1'h1;
      end else
         wr(6'h2c, 16'h0008);
      repeat (8) @(posedge aclk);
      if (!blk) for (int i = 0; i < 4; i++) mdl[4 + i] = now_w[i] & msk[i];
      chk("irq", irq, 1'h1);
      for (int i = 4; i < 8; i++) rdc(6'(i * 4));
   endtask
   task automatic alm(input logic [15:0] ctl);
      wr(6'h28, ctl);
      repeat (4) @(posedge aclk);
      tk = 0;
      pu = 0;
      repeat (200) begin
         @(posedge aclk);
         tk += half_second_tick;
         pu += alarm_pulse;
      end
   endtask

   initial begin
      rst(1'h1);
      for (int i = 0; i < 13; i++) rdc(6'(i * 4));
      wr(6'h34, 16'hffff);
      rd(6'h3c, d);
      for (int r = 0; r < 4; r++) begin
         for (int i = 0; i < 8; i++) wr(6'(i * 4), r == 0 ? 16'hffff : 16'(rnd()));
         for (int i = 0; i < 8; i++) rdc(6'(i * 4));
      end
      rst(1'h0);
      for (int i = 0; i < 13; i++) if (i != 11) rdc(6'(i * 4));
      rst(1'h1);
      for (int i = 4; i < 8; i++) rdc(6'(i * 4));
      for (int i = 8; i < 13; i++) if (i != 11) wr(6'(i * 4), 16'hffff);
      for (int i = 8; i < 13; i++) if (i != 11) rdc(6'(i * 4));
      wr(6'h28, 16'h0);
      ticks(3, 0);
      ticks(3, 31);
      ticks(6, 5);
      // timestamp capture and its interrupt
      wr(6'h30, 16'h0008);
      wr(6'h28, 16'h0001);
      rd(6'h2c, d);
      cap(1'h0, 1'h0);
      rd(6'h2c, d);
      chk("status", d & 32'h28, 32'h8);
      repeat (3) @(posedge aclk);
      chk("irq", irq, 1'h0);
      cap(1'h1, 1'h0);
      cap(1'h0, 1'h1);
      wr(6'h30, 16'h0);
      repeat (3) @(posedge aclk);
      chk("irq", irq, 1'h0);
      rd(6'h2c, d);
      chk("status", d & 32'h28, 32'h8);
      rd(6'h2c, d);
      chk("status", d & 32'h28, 32'h0);
      // alarm intervals
      now_w[0] <= 16'h1200;
      wr(6'h00, 16'h1200);
      alm(16'h8000);
      chk("alarm tick", pu >= tk - 1 && pu <= tk + 1 && tk > 10, 1'h1);
      alm(16'h8300);
      chk("alarm second", pu > 0 && pu < tk, 1'h1);
      alm(16'h8f00);
      chk("alarm never", pu, 0);
      wr(6'h00, 16'h0c00);
      alm(16'h8300);
      chk("alarm binary", pu, 0);
      // interval codes 1 to 9 with all compared digits equal
      for (int i = 0; i < 4; i++) now_w[i] <= mdl[i];
      for (int s = 1; s < 10; s++) begin
         alm(16'(16'h8000 | (s << 8)));
         chk("alarm code", pu >= tk / 2 - 1 && pu <= tk / 2 + 2 && tk > 10, 1'h1);
      end
      // month differs: yearly never, monthly still fires
      now_w[3] <= 16'h0001;
      alm(16'h8900);
      chk("alarm month", pu, 0);
      alm(16'h8800);
      chk("alarm date", pu > 0, 1'h1);
      complete_run();
   end
endmodule // tb_rtc_alarm_timestamp_calibration
`default_nettype wire
